// ==== rtl/uart_fifo_defs.svh ====
// Constants for the serial FIFO, time-out, baud and DMA pin block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UART_FIFO_DEFS_SVH
`define UART_FIFO_DEFS_SVH
// Register addresses on the three address pins
`define ADDR_DATA 3'h0
`define ADDR_IER 3'h1
`define ADDR_FCR_ISR 3'h2
`define ADDR_LCR 3'h3
`define ADDR_MCR 3'h4
`define ADDR_LSR 3'h5
`define ADDR_MSR 3'h6
`define ADDR_SPR 3'h7
// Field positions
`define FCR_ENABLE 0
`define FCR_RX_RESET 1
`define FCR_TX_RESET 2
`define FCR_DMA 3
`define LCR_DLAB 7
`define IER_RX 0
`define IER_TX 1
// Reset values
`define RST_BYTE 8'h00
`define RST_SPR 8'hff
`define RST_DIV 16'h0000
// Interrupt identification codes
`define ISR_NONE 4'h1
`define ISR_RX_DATA 4'h4
`define ISR_RX_TIMEOUT 4'hc
`define ISR_TX_EMPTY 4'h2
// Receive trigger levels, selected by FIFO_CONTROL_REG bits 7:6
`define TRIG_0 5'h01
`define TRIG_1 5'h04
`define TRIG_2 5'h08
`define TRIG_3 5'h0e
// Time-out: four bit times per word bit plus twelve
`define TO_MULT 7'h04
`define TO_EXTRA 7'h0c
`define WL_BASE 7'h05
`define TICKS_PER_BIT 4'hf
// FIFO geometry
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ==== rtl/uart_fifo_pkg.sv ====
// Shared types for the serial FIFO block.
// Assumes uart_fifo_defs.svh is on the include path.
`include "uart_fifo_defs.svh"
package uart_fifo_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [`FIFO_AW:0] level_t;
	// Receive-ready pin behaviour in DMA mode
	typedef enum logic {RXP_IDLE, RXP_ASSERTED} rx_pin_e;
endpackage : uart_fifo_pkg

// ==== rtl/uart_fifo_core.sv ====
// Transmit and receive FIFOs, receive time-out, baud generator and DMA pins.
// Assumes a serializer and deserializer outside, and synchronous host strobes.
//
// How it works
// - Sixteen-deep transmit and receive FIFOs, both enabled by FIFO_CONTROL_REG bit 0.
// - Receive trigger level programmable; transmit has none.
// - Time-out fires when data waits unread below the trigger level.
// - Data-available and time-out share one priority, enabled by INTERRUPT_ENABLE_REG bit 0.
// - Data-available fires once the count reaches the trigger level.
// - No time-out while the receive FIFO is empty.
// - Time-out count restarts at each stop-bit centre and each data read.
// - Time-out length is four times word length plus twelve bit times.
// - Generator accepts input clocks up to 24 MHz.
// - Generator divides by any 16-bit divisor from 1 to 65535.
// - Baud clock pin runs at sixteen times the bit rate.
// - Divisor held as high and low byte registers.
// - FIFO_CONTROL_REG bit 3 selects DMA mode for both FIFOs' ready pins.
// - Non-DMA receive-ready low when data present; DMA rises on empty.
// - DMA receive-ready falls at trigger level or on time-out.
// - Non-DMA transmit-ready low only when transmit FIFO empty.
// - DMA transmit-ready high only when transmit FIFO full.
// - Divisor bytes reachable only while LINE_CONTROL_REG bit 7 is set.
`timescale 1ns/1ps
`include "uart_fifo_defs.svh"

module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic flush, // Empties the FIFO
	input wire logic one_deep, // Capacity limited to one word
	input wire logic in_valid, // Write request
	output logic in_ready, // Room available
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Data available
	input wire logic out_ready, // Read request
	output logic [WIDTH-1:0] out_data, // Head of FIFO
	output logic [AW:0] level // Words held
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// Handshake terms, capacity shrinks to one in holding mode
	assign in_ready = count_r < (one_deep ? (AW+1)'(1) : (AW+1)'(DEPTH));
	assign out_valid = count_r != '0;
	assign out_data = mem[rd_ptr_r];
	assign level = count_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sync_fifo

module uart_fifo_core
	import uart_fifo_pkg::*;
(
	input wire logic clk_sys, // Oscillator input clock
	input wire logic rst, // Synchronous reset
	input wire logic [2:0] addr, // Register address pins
	input wire logic wr_en, // Register write strobe
	input wire logic rd_en, // Register read strobe
	input wire logic [7:0] wdata, // Write data bus
	output logic [7:0] rdata, // Read data, one cycle after rd_en
	input wire logic rx_char_valid, // Deserializer offers a character
	input wire logic [7:0] rx_char_data, // Received character
	output logic rx_char_ready, // Receive FIFO has room
	input wire logic rx_stop_centre, // Pulse at centre of a stop bit
	output logic tx_char_valid, // Transmit FIFO holds data
	output logic [7:0] tx_char_data, // Character for the serializer
	input wire logic tx_char_ready, // Serializer takes the character
	output logic sample_tick, // One-cycle 16x sample pulse
	output logic baud_clock_out_n, // 16x baud clock pin
	output logic receive_ready_n, // Receive ready pin
	output logic transmit_ready_n, // Transmit ready pin
	output logic irq // Interrupt request, high active
);
	byte_t ier_r, lcr_r, mcr_r, spr_r, rdata_r;
	logic fifo_en_r, dma_r, timeout_r, tick_r, baud_r, tx_ready_n_r, irq_r;
	logic [1:0] trig_sel_r;
	logic [7:0] baud_divisor_high, baud_divisor_low;
	logic [15:0] div_cnt_r;
	logic [3:0] tick_cnt_r;
	logic [6:0] to_cnt_r, to_limit;
	rx_pin_e rx_pin_r;
	logic dlab, fcr_wr, rx_flush, tx_flush, rhr_rd, thr_wr;
	logic rx_valid, tx_in_ready, tx_empty, rx_at_trig, rx_avail;
	logic div_hit, bit_tick, to_restart;
	byte_t rx_head;
	level_t rx_level, tx_level;
	logic [3:0] isr_code;

	// Trigger level decode, used by the interrupt and pin logic
	function automatic level_t trig_level(input logic [1:0] sel);
		case (sel)
			2'd0: trig_level = `TRIG_0;
			2'd1: trig_level = `TRIG_1;
			2'd2: trig_level = `TRIG_2;
			default: trig_level = `TRIG_3;
		endcase
	endfunction : trig_level

	// Access decode
	assign dlab = lcr_r[`LCR_DLAB];
	assign fcr_wr = wr_en && addr == `ADDR_FCR_ISR;
	assign rx_flush = fcr_wr && (wdata[`FCR_RX_RESET] || wdata[`FCR_ENABLE] != fifo_en_r);
	assign tx_flush = fcr_wr && (wdata[`FCR_TX_RESET] || wdata[`FCR_ENABLE] != fifo_en_r);
	assign rhr_rd = rd_en && addr == `ADDR_DATA && !dlab;
	assign thr_wr = wr_en && addr == `ADDR_DATA && !dlab;

	// Receive and transmit FIFOs
	sync_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_rx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(rx_flush),
		.one_deep(!fifo_en_r),
		.in_valid(rx_char_valid),
		.in_ready(rx_char_ready),
		.in_data(rx_char_data),
		.out_valid(rx_valid),
		.out_ready(rhr_rd),
		.out_data(rx_head),
		.level(rx_level)
	);
	sync_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_tx_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(tx_flush),
		.one_deep(!fifo_en_r),
		.in_valid(thr_wr),
		.in_ready(tx_in_ready),
		.in_data(wdata),
		.out_valid(tx_char_valid),
		.out_ready(tx_char_ready),
		.out_data(tx_char_data),
		.level(tx_level)
	);
	assign tx_empty = tx_level == '0;

	// Receive status: trigger only counts with FIFOs on
	assign rx_at_trig = rx_level >= trig_level(trig_sel_r);
	assign rx_avail = fifo_en_r ? rx_at_trig : rx_valid;

	// Control register writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ier_r <= `RST_BYTE;
			lcr_r <= `RST_BYTE;
			mcr_r <= `RST_BYTE;
			spr_r <= `RST_SPR;
			fifo_en_r <= 1'b0;
			dma_r <= 1'b0;
			trig_sel_r <= 2'd0;
		end else if (wr_en) begin
			case (addr)
				`ADDR_IER: if (!dlab) ier_r <= {4'h0, wdata[3:0]};
				`ADDR_FCR_ISR: begin
					fifo_en_r <= wdata[`FCR_ENABLE];
					dma_r <= wdata[`FCR_DMA];
					trig_sel_r <= wdata[7:6];
				end
				`ADDR_LCR: lcr_r <= wdata;
				`ADDR_MCR: mcr_r <= {3'h0, wdata[4:0]};
				`ADDR_SPR: spr_r <= wdata;
				default: ;
			endcase
		end
	end

	// Divisor bytes share the data and enable addresses under the latch bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			baud_divisor_low <= `RST_BYTE; // Divisor resets to zero
			baud_divisor_high <= `RST_BYTE;
		end else if (wr_en && dlab) begin
			if (addr == `ADDR_DATA) begin
				baud_divisor_low <= wdata;
			end
			if (addr == `ADDR_IER) begin
				baud_divisor_high <= wdata;
			end
		end
	end

	// Interrupt identification, data and time-out on one level
	always_comb begin
		if (ier_r[`IER_RX] && timeout_r) begin
			isr_code = `ISR_RX_TIMEOUT;
		end else if (ier_r[`IER_RX] && rx_avail) begin
			isr_code = `ISR_RX_DATA;
		end else if (ier_r[`IER_TX] && tx_empty) begin
			isr_code = `ISR_TX_EMPTY;
		end else begin
			isr_code = `ISR_NONE;
		end
	end

	// Read data register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= `RST_BYTE;
		end else if (rd_en) begin
			case (addr)
				`ADDR_DATA: rdata_r <= dlab ? baud_divisor_low : (rx_valid ? rx_head : `RST_BYTE);
				`ADDR_IER: rdata_r <= dlab ? baud_divisor_high : ier_r;
				`ADDR_FCR_ISR: rdata_r <= {{2{fifo_en_r}}, 2'b00, isr_code};
				`ADDR_LCR: rdata_r <= lcr_r;
				`ADDR_MCR: rdata_r <= mcr_r;
				`ADDR_LSR: rdata_r <= {1'b0, tx_empty, tx_empty, 4'h0, rx_valid};
				`ADDR_SPR: rdata_r <= spr_r;
				default: rdata_r <= `RST_BYTE;
			endcase
		end
	end

	// Baud divider: one sample tick per divisor input clocks
	assign div_hit = {baud_divisor_high, baud_divisor_low} != 16'h0000 &&
		div_cnt_r >= {baud_divisor_high, baud_divisor_low} - 16'h0001;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_cnt_r <= `RST_DIV;
			tick_r <= 1'b0;
			baud_r <= 1'b1;
		end else begin
			div_cnt_r <= div_hit ? `RST_DIV : div_cnt_r + 16'h0001;
			tick_r <= div_hit;
			baud_r <= !div_hit;
		end
	end

	// Bit time: sixteen sample ticks
	assign bit_tick = tick_r && tick_cnt_r == `TICKS_PER_BIT;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tick_cnt_r <= 4'h0;
		end else if (tick_r) begin
			tick_cnt_r <= tick_cnt_r + 4'h1;
		end
	end

	// Receive time-out counter and flag
	assign to_limit = `TO_MULT * (`WL_BASE + {5'h00, lcr_r[1:0]}) + `TO_EXTRA;
	assign to_restart = rx_stop_centre || rhr_rd;
	always_ff @(posedge clk_sys) begin
		if (rst || to_restart) begin
			to_cnt_r <= 7'h00;
		end else if (bit_tick && to_cnt_r < to_limit) begin
			to_cnt_r <= to_cnt_r + 7'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst || !fifo_en_r || !rx_valid || rx_flush) begin
			timeout_r <= 1'b0;
		end else if (!to_restart && to_cnt_r == to_limit && !rx_at_trig) begin
			timeout_r <= 1'b1;
		end else if (to_restart) begin
			timeout_r <= 1'b0;
		end
	end

	// Receive-ready pin
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_pin_r <= RXP_IDLE;
		end else if (!dma_r || !fifo_en_r) begin
			rx_pin_r <= rx_valid ? RXP_ASSERTED : RXP_IDLE;
		end else begin
			case (rx_pin_r)
				RXP_IDLE: if (rx_at_trig || timeout_r) rx_pin_r <= RXP_ASSERTED;
				RXP_ASSERTED: if (!rx_valid) rx_pin_r <= RXP_IDLE;
				default: rx_pin_r <= RXP_IDLE;
			endcase
		end
	end

	// Transmit-ready pin and interrupt line
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_ready_n_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (dma_r && fifo_en_r) begin
				tx_ready_n_r <= !tx_in_ready;
			end else begin
				tx_ready_n_r <= !tx_empty;
			end
			irq_r <= isr_code != `ISR_NONE;
		end
	end

	// Outputs
	assign rdata = rdata_r;
	assign sample_tick = tick_r;
	assign baud_clock_out_n = baud_r;
	assign receive_ready_n = rx_pin_r != RXP_ASSERTED;
	assign transmit_ready_n = tx_ready_n_r;
	assign irq = irq_r;
endmodule : uart_fifo_core

// ==== test/uart_fifo_core_sva.sv ====
// Checker for the FIFO, time-out, baud and ready-pin block.
// Assumes binding to uart_fifo_core; mirrors host writes it needs.
`timescale 1ns/1ps
module uart_fifo_core_sva (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic [2:0] addr, // Address
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	input wire logic [7:0] wdata, // Write data
	input wire logic [7:0] rdata, // Read data
	input wire logic rx_char_valid, // Char offered
	input wire logic [7:0] rx_char_data, // Char
	input wire logic rx_char_ready, // Rx room
	input wire logic rx_stop_centre, // Stop centre
	input wire logic tx_char_valid, // Tx data
	input wire logic [7:0] tx_char_data, // Tx char
	input wire logic tx_char_ready, // Tx taken
	input wire logic sample_tick, // 16x tick
	input wire logic baud_clock_out_n, // Baud pin
	input wire logic receive_ready_n, // Rx pin
	input wire logic transmit_ready_n, // Tx pin
	input wire logic irq // Interrupt
);
	logic lcr7_r;
	logic dma_r;
	logic [3:0] ier_r;
	logic [15:0] div_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Mirror of the host register writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lcr7_r <= 1'b0;
			dma_r <= 1'b0;
			ier_r <= 4'h0;
			div_r <= 16'h0000;
		end else if (wr_en) begin
			if (addr == 3'h3) lcr7_r <= wdata[7];
			if (addr == 3'h2) dma_r <= wdata[3] & wdata[0];
			if (addr == 3'h1 && !lcr7_r) ier_r <= wdata[3:0];
			if (addr == 3'h1 && lcr7_r) div_r[15:8] <= wdata;
			if (addr == 3'h0 && lcr7_r) div_r[7:0] <= wdata;
		end
	end
	a_tx_pin_plain: assert property (!dma_r && !$past(dma_r) |-> transmit_ready_n == $past(tx_char_valid))
		else $error("transmit ready pin wrong in plain mode");
	a_rx_pin_fall: assert property ((rx_char_valid && rx_char_ready && !dma_r) ##1 !(rd_en && addr == 3'h0)
		|=> !receive_ready_n)
		else $error("receive ready pin did not fall");
	a_baud_pin_tick: assert property (sample_tick == !baud_clock_out_n)
		else $error("baud pin not tied to tick");
	a_tick_period_twelve: assert property (sample_tick && div_r == 16'h000c
		|=> (!sample_tick) [*8] ##1 (!sample_tick) [*3] ##1 sample_tick)
		else $error("tick spacing not twelve");
	a_irq_needs_enable: assert property (ier_r == 4'h0 && $past(ier_r) == 4'h0 && $past(ier_r, 2) == 4'h0 |-> !irq)
		else $error("interrupt with nothing enabled");
	a_rdata_holds: assert property (!$past(rd_en) |-> $stable(rdata))
		else $error("read data changed without a read");
	a_tx_first_char: assert property (wr_en && addr == 3'h0 && !lcr7_r && !tx_char_valid
		|=> tx_char_valid && tx_char_data == $past(wdata))
		else $error("written char not at transmit head");
	a_no_tick_zero: assert property (div_r == 16'h0000 && $past(div_r) == 16'h0000 |-> !sample_tick)
		else $error("tick with zero divisor");
	c_tick: cover property (sample_tick);
	c_irq: cover property (irq);
	c_tx_full: cover property (dma_r && transmit_ready_n);
endmodule : uart_fifo_core_sva
bind uart_fifo_core uart_fifo_core_sva chk_i (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_en(wr_en),
	.rd_en(rd_en), .wdata(wdata), .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
	.rx_char_ready(rx_char_ready), .rx_stop_centre(rx_stop_centre), .tx_char_valid(tx_char_valid),
	.tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready), .sample_tick(sample_tick),
	.baud_clock_out_n(baud_clock_out_n), .receive_ready_n(receive_ready_n),
	.transmit_ready_n(transmit_ready_n), .irq(irq));

// ==== test/serial_far_end.sv ====
// Far-end model: deserializer offering chars, serializer taking them.
// Assumes the bench calls send_char and drives stall.
`timescale 1ns/1ps
module serial_far_end (
	input wire logic clk_sys, // Clock
	input wire logic stall, // Hold off serializer
	input wire logic rx_char_ready, // Rx room
	input wire logic tx_char_valid, // Tx data offered
	output logic rx_char_valid, // Char offered
	output logic [7:0] rx_char_data, // Char
	output logic rx_stop_centre, // Stop centre pulse
	output logic tx_char_ready // Serializer takes
);
	int taken = 0;
	initial rx_char_valid = 1'b0;
	initial rx_char_data = 8'h00;
	initial rx_stop_centre = 1'b0;
	assign tx_char_ready = !stall;
	// Count chars the serializer takes
	always @(posedge clk_sys) if (tx_char_valid && tx_char_ready) taken <= taken + 1;
	// Offer one char until taken, then mark its stop bit
	task automatic send_char(input logic [7:0] c);
		@(negedge clk_sys);
		rx_char_valid = 1'b1;
		rx_char_data = c;
		while (!rx_char_ready) @(negedge clk_sys);
		@(negedge clk_sys);
		rx_char_valid = 1'b0;
		rx_char_data = ~c; // No stale value once released
		rx_stop_centre = 1'b1;
		@(negedge clk_sys);
		rx_stop_centre = 1'b0;
	endtask : send_char
endmodule : serial_far_end

// ==== test/uart_fifo_core_bench.sv ====
// Bench for the FIFO, time-out, baud and ready-pin block.
// Assumes the checker binds itself; inputs change at falling edges.
`timescale 1ns/1ps
module uart_fifo_core_bench;
	import uart_fifo_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic stall = 1'b0;
	logic [7:0] rdata, rx_char_data, tx_char_data;
	logic rx_char_valid, rx_char_ready, rx_stop_centre, tx_char_valid, tx_char_ready;
	logic sample_tick, baud_clock_out_n, receive_ready_n, transmit_ready_n, irq;
	int num_errors = 0;
	int compares = 0;
	int n;
	byte_t v;
	always #10 clk_sys = ~clk_sys;
	uart_fifo_core DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
		.rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_char_ready(rx_char_ready),
		.rx_stop_centre(rx_stop_centre), .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
		.tx_char_ready(tx_char_ready), .sample_tick(sample_tick), .baud_clock_out_n(baud_clock_out_n),
		.receive_ready_n(receive_ready_n), .transmit_ready_n(transmit_ready_n), .irq(irq));
	serial_far_end far (.clk_sys(clk_sys), .stall(stall), .rx_char_ready(rx_char_ready),
		.tx_char_valid(tx_char_valid), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_stop_centre(rx_stop_centre), .tx_char_ready(tx_char_ready));
	// Verdict and end of run
	task automatic tally_and_finish;
		$display("Errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic cmp8(input byte_t got, input byte_t exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t byte %h want %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t bit %b want %b", $time, got, exp);
		end
	endtask : cmp1
	task automatic wr(input logic [2:0] a, input byte_t d);
		@(negedge clk_sys);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk_sys);
		wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output byte_t d);
		@(negedge clk_sys);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_sys);
		rd_en = 1'b0;
		@(negedge clk_sys);
		d = rdata;
	endtask : rd
	task automatic chk(input logic [2:0] a, input byte_t exp);
		byte_t g;
		rd(a, g);
		cmp8(g, exp);
	endtask : chk
	task automatic idle(input int c);
		repeat (c) @(negedge clk_sys);
	endtask : idle
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		cmp1(transmit_ready_n, 1'b0);
		cmp1(receive_ready_n, 1'b1);
		cmp1(irq, 1'b0);
		wr(3'h1, 8'h01);
		wr(3'h3, 8'h80);
		wr(3'h1, 8'h00);
		wr(3'h0, 8'h0c); // Divisor for 9600 baud at 1.8432 MHz
		chk(3'h1, 8'h00);
		chk(3'h0, 8'h0c);
		wr(3'h3, 8'h00);
		chk(3'h1, 8'h01);
		// Spacing of sample ticks
		n = 0;
		while (!sample_tick) @(negedge clk_sys);
		do begin
			@(negedge clk_sys);
			n++;
		end while (!sample_tick && n < 100);
		cmp8(8'(n), 8'h0c);
		// Time-out below trigger level 14, five-bit words
		wr(3'h2, 8'hc1);
		for (int i = 0; i < 3; i++) far.send_char(8'ha1 + 8'(i));
		idle(2);
		cmp1(receive_ready_n, 1'b0);
		chk(3'h2, 8'hc1);
		idle(32 * 16 * 12 - 250);
		chk(3'h2, 8'hc1);
		idle(500);
		chk(3'h2, 8'hcc);
		cmp1(irq, 1'b1);
		for (int i = 0; i < 3; i++) begin
			chk(3'h0, 8'ha1 + 8'(i));
			rd(3'h5, v);
			cmp1(v[0], i < 2);
		end
		idle(3);
		chk(3'h2, 8'hc1);
		cmp1(irq, 1'b0);
		// DMA receive pin with trigger level 4
		wr(3'h2, 8'h49);
		for (int i = 0; i < 4; i++) begin
			far.send_char(8'h30 + 8'(i));
			idle(2);
			cmp1(receive_ready_n, i < 3);
		end
		chk(3'h2, 8'hc4);
		for (int i = 0; i < 4; i++) chk(3'h0, 8'h30 + 8'(i));
		idle(2);
		cmp1(receive_ready_n, 1'b1);
		// DMA transmit pin while the serializer stalls
		stall = 1'b1;
		for (int i = 0; i < 16; i++) begin
			cmp1(transmit_ready_n, 1'b0);
			wr(3'h0, 8'(i));
		end
		idle(2);
		cmp1(transmit_ready_n, 1'b1);
		wr(3'h2, 8'h41);
		idle(2);
		cmp1(transmit_ready_n, 1'b1);
		stall = 1'b0;
		idle(20);
		cmp8(8'(far.taken), 8'h10);
		cmp1(transmit_ready_n, 1'b0);
		tally_and_finish();
	end
	// Watchdog well past the expected run
	initial begin
		#1ms;
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : uart_fifo_core_bench
